// [tb_vic_top.sv]
// self-checking testbench of the vectored interrupt controller
`timescale 1ns/1ps
module tb_vic_top;
  logic i_mclk, i_nrst, mem_wr, mem_rd, standby, run;
  logic [11:0] addr;
  logic [3:0] wdata, bmask, rdata, ctl, pins, ack_delay, d;
  logic [1:0] sdat, status;
  logic [5:0] tick;
  logic boundary, ack, int_req;
  logic [2:0] int_vec, taken;
  logic [7:0] takes, last_takes;
  logic [6:0] vrl;
  logic [9:0] wake, acc;
  logic [13:0] vaddr;
  int miscompares, comparisons;
  int src_idx [6] = '{0, 4, 5, 6, 7, 9};
  logic [3:0] pv [6] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h0};
  logic [9:0] pe [6] = '{10'h002, 10'h002, 10'h100, 10'h000, 10'h000, 10'h008};
  vic_top dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_mem_wr(mem_wr), .i_mem_rd(mem_rd),
    .i_mem_addr(addr), .i_mem_wdata(wdata), .i_mem_bmask(bmask), .o_mem_rdata(rdata),
    .i_ei_instr(ctl[0]), .i_di_instr(ctl[1]), .i_bt_tick(tick[0]), .i_serial_end(tick[1]),
    .i_evc_match(tick[2]), .i_pgen_match(tick[3]), .i_key_scan(tick[4]),
    .i_watch_tick(tick[5]), .i_ext_pin_a(pins[0]), .i_ext_pin_b(pins[1]),
    .i_ext_pin_c(pins[2]), .i_ext_pin_d(pins[3]), .i_standby(standby),
    .i_instr_boundary(boundary), .i_int_ack(ack), .i_reti(ctl[2]), .i_reti_status(sdat),
    .i_status_wr(ctl[3]), .i_status_wdata(sdat), .o_vectored_request_line(vrl),
    .o_wakeup(wake), .o_int_req(int_req), .o_int_vector(int_vec), .o_vector_addr(vaddr),
    .o_service_status(status));
  vic_cpu_model u_cpu (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_run(run), .i_int_req(int_req),
    .i_int_vector(int_vec), .i_ack_delay(ack_delay), .o_instr_boundary(boundary),
    .o_int_ack(ack), .o_taken_vector(taken), .o_take_count(takes));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [3:0] v, input logic [3:0] m);
    @(posedge i_mclk);
    mem_wr <= 1'b1;
    addr <= a;
    wdata <= v;
    bmask <= m;
    @(posedge i_mclk);
    mem_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge i_mclk);
    mem_rd <= 1'b1;
    addr <= a;
    @(posedge i_mclk);
    mem_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic ctl_pulse(input int b, input logic [1:0] s);
    @(posedge i_mclk);
    ctl[b] <= 1'b1;
    sdat <= s;
    @(posedge i_mclk);
    ctl <= 4'h0;
    #1;
  endtask
  task automatic clr_flags;
    for (int k = 0; k < 3; k++) wr(12'hFB4 + 12'(k), 4'h0, 4'hF);
  endtask
  // pin a pulse of w cycles; post must cover the filter's sampling delay
  task automatic apulse(input int w, input int post, input logic [9:0] e);
    @(posedge i_mclk);
    pins[0] <= 1'b1;
    repeat (w) @(posedge i_mclk);
    pins[0] <= 1'b0;
    repeat (post) @(posedge i_mclk);
    #1 chk(14'(wake), 14'(e));
    clr_flags();
  endtask
  task automatic take(input logic [2:0] v, input logic [1:0] st);
    int n;
    n = 0;
    while (takes === last_takes && n < 100) begin
      @(posedge i_mclk);
      n++;
    end
    repeat (3) @(posedge i_mclk);
    #1 chk(14'(takes), 14'(last_takes + 8'h01));
    chk(14'(taken), 14'(v));
    chk(14'(status), 14'(st));
    last_takes = takes;
    ack_delay <= 4'h0;
  endtask
  task automatic none_taken;
    repeat (20) @(posedge i_mclk);
    #1 chk(14'(takes), 14'(last_takes));
  endtask
  task complete_run;
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end
  initial begin
    {i_nrst, mem_wr, mem_rd, standby, addr, wdata, bmask, ctl, sdat, tick, pins} = '0;
    run = 1'b1;
    ack_delay = 4'h3;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    for (int a = 0; a < 11; a++) begin
      rd(12'hFB0 + 12'(a));
      chk(14'(d), 14'h0000);
    end
    wr(vic_pkg::ADDR_IPS, 4'hF, 4'hF);
    rd(vic_pkg::ADDR_IPS);
    chk(14'(d), 14'h000F);
    ctl_pulse(1, 2'h0);
    rd(vic_pkg::ADDR_IPS);
    chk(14'(d), 14'h0007);
    ctl_pulse(0, 2'h0);
    rd(vic_pkg::ADDR_IPS);
    chk(14'(d), 14'h000F);
    wr(vic_pkg::ADDR_IPS, 4'h0, 4'hF);
    wr(12'hFB8, 4'hF, 4'hF);
    wr(12'hFB9, 4'hF, 4'hF);
    wr(12'hFBA, 4'h3, 4'hF);
    wr(12'hFB4, 4'h4, 4'h4);
    wr(12'hFB5, 4'h1, 4'h1);
    chk(14'(vrl), 14'h000A);
    chk(14'(wake), 14'h0014);
    wr(12'hFB8, 4'h0, 4'h4);
    chk(14'(vrl), 14'h0008);
    wr(12'hFB8, 4'hF, 4'hF);
    clr_flags();
    acc = 10'h000;
    for (int j = 0; j < 6; j++) begin
      @(posedge i_mclk);
      tick[j] <= 1'b1;
      @(posedge i_mclk);
      tick <= 6'h00;
      acc = acc | (10'h001 << src_idx[j]);
      #1 chk(14'(wake), 14'(acc));
    end
    // interrupts stay off while edge modes change, and flags are cleared after
    wr(12'hFB1, 4'h1, 4'hF);
    clr_flags();
    for (int j = 0; j < 6; j++) begin
      @(posedge i_mclk);
      pins <= pv[j];
      repeat (6) @(posedge i_mclk);
      #1 chk(14'(wake), 14'(pe[j]));
      clr_flags();
    end
    apulse(1, 8, 10'h000);
    apulse(4, 8, 10'h004);
    standby <= 1'b1;
    apulse(6, 8, 10'h000);
    standby <= 1'b0;
    wr(12'hFB0, 4'h8, 4'hF);
    repeat (16) @(posedge i_mclk);
    clr_flags();
    apulse(40, 200, 10'h000);
    apulse(200, 200, 10'h004);
    wr(12'hFB0, 4'h0, 4'hF);
    clr_flags();
    wr(12'hFB5, 4'h2, 4'h2);
    wr(12'hFB4, 4'h8, 4'h8);
    last_takes = takes;
    ctl_pulse(0, 2'h0);
    take(3'h3, 2'h1);
    chk(14'(vaddr), 14'h0006);
    chk(14'(wake), 14'h0020);
    none_taken();
    ctl_pulse(2, vic_pkg::ST_0);
    take(3'h5, 2'h1);
    ctl_pulse(1, 2'h0);
    wr(vic_pkg::ADDR_IPS, 4'h7, 4'hF);
    ctl_pulse(0, 2'h0);
    wr(12'hFB5, 4'h8, 4'h8);
    take(3'h7, 2'h2);
    wr(12'hFB4, 4'h4, 4'h4);
    none_taken();
    ctl_pulse(3, vic_pkg::ST_0);
    take(3'h2, 2'h1);
    ctl_pulse(1, 2'h0);
    ctl_pulse(3, vic_pkg::ST_0);
    wr(12'hFB5, 4'h4, 4'h4);
    none_taken();
    chk(14'(vrl), 14'h0020);
    clr_flags();
    wr(12'hFB4, 4'h3, 4'h3);
    ctl_pulse(0, 2'h0);
    take(3'h1, 2'h1);
    chk(14'(wake), 14'h0003);
    wr(12'hFB8, 4'h0, 4'h2);
    ctl_pulse(3, vic_pkg::ST_0);
    take(3'h1, 2'h1);
    rd(12'hFB4);
    chk(14'(d), 14'h0002);
    complete_run();
  end
endmodule // tb_vic_top

// [vic_cpu_model.sv]
// behavioural cpu core that takes presented vectored requests
`timescale 1ns/1ps
module vic_cpu_model (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_run,
  input wire logic i_int_req,
  input wire logic [2:0] i_int_vector,
  input wire logic [3:0] i_ack_delay,
  output logic o_instr_boundary,
  output logic o_int_ack,
  output logic [2:0] o_taken_vector,
  output logic [7:0] o_take_count
);
  logic [3:0] wait_cnt;
  // every cycle ends an instruction while running; a slow ack proves the request holds
  assign o_instr_boundary = i_run;
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      wait_cnt <= 4'h0;
      o_int_ack <= 1'b0;
      o_taken_vector <= 3'h0;
      o_take_count <= 8'h00;
    end else if (o_int_ack) begin
      o_int_ack <= 1'b0;
    end else if (i_int_req) begin
      if (wait_cnt == i_ack_delay) begin
        o_int_ack <= 1'b1;
        o_taken_vector <= i_int_vector;
        o_take_count <= o_take_count + 8'h01;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule // vic_cpu_model

// [vic_noise_filter.sv]
// sampling noise filter for external pin a
`timescale 1ns/1ps
module vic_noise_filter (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_sample_en,
  input wire logic i_pin,
  output logic o_level
);

  logic sample;

  // a level is accepted only when two successive samples agree
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      sample <= 1'b0;
    end else if (i_sample_en) begin
      sample <= i_pin;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_level <= 1'b0;
    end else if (i_sample_en && (sample == i_pin)) begin
      o_level <= i_pin;
    end
  end

endmodule // vic_noise_filter

// [vic_pkg.sv]
// shared constants and types of the vectored interrupt controller
package vic_pkg;

  // data memory addresses of the controller nibbles
  localparam logic [11:0] ADDR_IM_A = 12'hFB0;
  localparam logic [11:0] ADDR_IM_B = 12'hFB1;
  localparam logic [11:0] ADDR_IPS = 12'hFB2;
  localparam logic [11:0] ADDR_REQ_BASE = 12'hFB4;
  localparam logic [11:0] ADDR_EN_BASE = 12'hFB8;

  // flag positions, one per source
  localparam int NUM_FLAGS = 10;
  localparam int NUM_GROUPS = 3;
  localparam int F_BT = 0;
  localparam int F_PIN_D = 1;
  localparam int F_PIN_A = 2;
  localparam int F_PIN_B = 3;
  localparam int F_SERIAL = 4;
  localparam int F_EVC = 5;
  localparam int F_PGEN = 6;
  localparam int F_KEY = 7;
  localparam int F_PIN_C = 8;
  localparam int F_WATCH = 9;

  // vectored requests 1..7
  localparam int NUM_VEC = 7;
  localparam int VEC_W = 3;
  localparam int VEC_ADDR_W = 14;

  // priority select register layout
  localparam int IPS_IME_BIT = 3;
  localparam logic [3:0] IPS_RESET = 4'h0;
  localparam logic [2:0] HIGH_NONE = 3'h0;

  // edge mode register layout
  localparam int IM_SCLK_BIT = 3;
  localparam logic [3:0] IM_RESET = 4'h0;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h3;

  // interrupt servicing status values
  localparam logic [1:0] ST_0 = 2'h0;
  localparam logic [1:0] ST_1 = 2'h1;
  localparam logic [1:0] ST_2 = 2'h2;

  // oscillator divider for the pin a sample clock
  localparam int FX_DIV = 64;
  localparam int FX_DIV_W = 6;

  typedef enum logic {VIC_IDLE, VIC_PRESENT} vic_pres_state_t;

endpackage

// [vic_top.sv]
// vectored interrupt controller: flags, enables, priority select, edge detect, vector presenter
`timescale 1ns/1ps
module vic_top (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [11:0] i_mem_addr,
  input wire logic [3:0] i_mem_wdata,
  input wire logic [3:0] i_mem_bmask,
  output logic [3:0] o_mem_rdata,
  input wire logic i_ei_instr,
  input wire logic i_di_instr,
  input wire logic i_bt_tick,
  input wire logic i_serial_end,
  input wire logic i_evc_match,
  input wire logic i_pgen_match,
  input wire logic i_key_scan,
  input wire logic i_watch_tick,
  input wire logic i_ext_pin_a,
  input wire logic i_ext_pin_b,
  input wire logic i_ext_pin_c,
  input wire logic i_ext_pin_d,
  input wire logic i_standby,
  input wire logic i_instr_boundary,
  input wire logic i_int_ack,
  input wire logic i_reti,
  input wire logic [1:0] i_reti_status,
  input wire logic i_status_wr,
  input wire logic [1:0] i_status_wdata,
  output logic [6:0] o_vectored_request_line,
  output logic [9:0] o_wakeup,
  output logic o_int_req,
  output logic [2:0] o_int_vector,
  output logic [13:0] o_vector_addr,
  output logic [1:0] o_service_status
);

  logic [vic_pkg::NUM_FLAGS-1:0] req_flag;
  logic [vic_pkg::NUM_FLAGS-1:0] en_flag;
  logic [vic_pkg::NUM_FLAGS-1:0] hw_set;
  logic [vic_pkg::NUM_FLAGS-1:0] ack_clr;
  logic [11:0] req_pad;
  logic [11:0] en_pad;
  logic [3:0] interrupt_priority_select;
  logic [3:0] im_a;
  logic [3:0] im_b;
  logic [1:0] service_status;
  logic [vic_pkg::FX_DIV_W-1:0] fx_cnt;
  logic fx_tick;
  logic sample_en;
  logic pin_a_level;
  logic pin_a_prev;
  logic pin_b_prev;
  logic pin_c_prev;
  logic pin_d_prev;
  logic [vic_pkg::NUM_VEC:1] vreq;
  logic [vic_pkg::NUM_VEC:1] high_mask;
  logic [vic_pkg::NUM_VEC:1] eligible;
  logic pick_valid;
  logic [2:0] pick_vec;
  logic ack_take;
  vic_pkg::vic_pres_state_t state;
  vic_pkg::vic_pres_state_t next_state;

  // masked nibble update used by the edge mode and priority select registers
  function automatic logic [3:0] merge_nibble(input logic [3:0] old_val,
                                              input logic [3:0] data,
                                              input logic [3:0] mask);
    merge_nibble = (old_val & ~mask) | (data & mask);
  endfunction

  // edge detector selected by a two-bit mode
  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic prev,
                                    input logic now);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = prev & ~now;
    case (mode)
      vic_pkg::EDGE_RISE: edge_hit = rise;
      vic_pkg::EDGE_FALL: edge_hit = fall;
      vic_pkg::EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // divided oscillator tick, free running from reset
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      fx_cnt <= '0;
    end else begin
      fx_cnt <= fx_cnt + 1'b1;
    end
  end

  assign fx_tick = (fx_cnt == vic_pkg::FX_DIV_W'(vic_pkg::FX_DIV - 1));

  // the sampler has no clock in standby, so pin a cannot wake the device
  assign sample_en = !i_standby &&
                     (im_a[vic_pkg::IM_SCLK_BIT] ? fx_tick : 1'b1);

  vic_noise_filter u_filter (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_sample_en(sample_en),
    .i_pin(i_ext_pin_a),
    .o_level(pin_a_level)
  );

  // previous pin levels for edge detection
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      pin_a_prev <= 1'b0;
      pin_b_prev <= 1'b0;
      pin_c_prev <= 1'b0;
      pin_d_prev <= 1'b0;
    end else begin
      pin_a_prev <= pin_a_level;
      pin_b_prev <= i_ext_pin_b;
      pin_c_prev <= i_ext_pin_c;
      pin_d_prev <= i_ext_pin_d;
    end
  end

  // hardware set sources
  always_comb begin
    hw_set = '0;
    hw_set[vic_pkg::F_BT] = i_bt_tick;
    hw_set[vic_pkg::F_SERIAL] = i_serial_end;
    hw_set[vic_pkg::F_EVC] = i_evc_match;
    hw_set[vic_pkg::F_PGEN] = i_pgen_match;
    hw_set[vic_pkg::F_KEY] = i_key_scan;
    hw_set[vic_pkg::F_WATCH] = i_watch_tick;
    hw_set[vic_pkg::F_PIN_D] = pin_d_prev ^ i_ext_pin_d;
    hw_set[vic_pkg::F_PIN_A] = edge_hit(im_a[1:0], pin_a_prev, pin_a_level);
    hw_set[vic_pkg::F_PIN_B] = edge_hit(im_b[1:0], pin_b_prev, i_ext_pin_b);
    hw_set[vic_pkg::F_PIN_C] = i_ext_pin_c & ~pin_c_prev;
  end

  // request and enable flags, one pair per source
  genvar gi;
  generate
    for (gi = 0; gi < vic_pkg::NUM_FLAGS; gi++) begin : g_flag
      localparam int GRP = gi / 4;
      localparam int BIT = gi % 4;
      logic req_wr;
      logic en_wr;
      assign req_wr = i_mem_wr && i_mem_bmask[BIT] &&
                      (i_mem_addr == vic_pkg::ADDR_REQ_BASE + 12'(GRP));
      assign en_wr = i_mem_wr && i_mem_bmask[BIT] &&
                     (i_mem_addr == vic_pkg::ADDR_EN_BASE + 12'(GRP));

      // a hardware set beats a clear in the same cycle
      always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
          req_flag[gi] <= 1'b0;
        end else if (hw_set[gi]) begin
          req_flag[gi] <= 1'b1;
        end else if (req_wr) begin
          req_flag[gi] <= i_mem_wdata[BIT];
        end else if (ack_clr[gi]) begin
          req_flag[gi] <= 1'b0;
        end
      end

      always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
          en_flag[gi] <= 1'b0;
        end else if (en_wr) begin
          en_flag[gi] <= i_mem_wdata[BIT];
        end
      end
    end
  endgenerate

  assign req_pad = {2'b00, req_flag};
  assign en_pad = {2'b00, en_flag};

  // edge mode registers; a mode change alone raises no flag, only a pin transition does
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      im_a <= vic_pkg::IM_RESET;
      im_b <= vic_pkg::IM_RESET;
    end else if (i_mem_wr && (i_mem_addr == vic_pkg::ADDR_IM_A)) begin
      im_a <= merge_nibble(im_a, i_mem_wdata, i_mem_bmask);
    end else if (i_mem_wr && (i_mem_addr == vic_pkg::ADDR_IM_B)) begin
      im_b <= merge_nibble(im_b, i_mem_wdata, i_mem_bmask);
    end
  end

  // priority select; enable and disable instructions override a same-cycle write
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      interrupt_priority_select <= vic_pkg::IPS_RESET;
    end else if (i_ei_instr) begin
      interrupt_priority_select[vic_pkg::IPS_IME_BIT] <= 1'b1;
    end else if (i_di_instr) begin
      interrupt_priority_select[vic_pkg::IPS_IME_BIT] <= 1'b0;
    end else if (i_mem_wr && (i_mem_addr == vic_pkg::ADDR_IPS)) begin
      interrupt_priority_select <= merge_nibble(interrupt_priority_select, i_mem_wdata, i_mem_bmask);
    end
  end

  // vectored requests; vector 1 is the or of the two shared sources
  always_comb begin
    vreq = '0;
    vreq[1] = (req_flag[vic_pkg::F_BT] & en_flag[vic_pkg::F_BT]) |
              (req_flag[vic_pkg::F_PIN_D] & en_flag[vic_pkg::F_PIN_D]);
    for (int n = 2; n <= vic_pkg::NUM_VEC; n++) begin
      vreq[n] = req_flag[n] & en_flag[n];
    end
  end

  assign o_vectored_request_line = vreq;
  // test sources wake the device too, they just have no vector
  assign o_wakeup = req_flag & en_flag;

  // high interrupt mask from the low select bits
  always_comb begin
    high_mask = '0;
    for (int n = 1; n <= vic_pkg::NUM_VEC; n++) begin
      high_mask[n] = (interrupt_priority_select[2:0] == 3'(n)) && (interrupt_priority_select[2:0] != vic_pkg::HIGH_NONE);
    end
  end

  // eligibility by master enable and servicing status
  always_comb begin
    eligible = '0;
    if (interrupt_priority_select[vic_pkg::IPS_IME_BIT]) begin
      case (service_status)
        vic_pkg::ST_0: eligible = vreq;
        vic_pkg::ST_1: eligible = vreq & high_mask;
        default: eligible = '0;
      endcase
    end
  end

  // fixed order, lowest number first
  always_comb begin
    pick_valid = 1'b0;
    pick_vec = 3'h0;
    for (int n = vic_pkg::NUM_VEC; n >= 1; n--) begin
      if (eligible[n]) begin
        pick_valid = 1'b1;
        pick_vec = 3'(n);
      end
    end
  end

  // presenter
  always_comb begin
    next_state = state;
    case (state)
      vic_pkg::VIC_IDLE: begin
        if (i_instr_boundary && pick_valid) begin
          next_state = vic_pkg::VIC_PRESENT;
        end
      end
      vic_pkg::VIC_PRESENT: begin
        if (i_int_ack) begin
          next_state = vic_pkg::VIC_IDLE;
        end
      end
      default: next_state = vic_pkg::VIC_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      state <= vic_pkg::VIC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // vector number and table address latched once, stable while presented
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_int_vector <= 3'h0;
      o_vector_addr <= '0;
    end else if (state == vic_pkg::VIC_IDLE && i_instr_boundary && pick_valid) begin
      o_int_vector <= pick_vec;
      o_vector_addr <= {10'h000, pick_vec, 1'b0};
    end
  end

  assign o_int_req = (state == vic_pkg::VIC_PRESENT);
  assign ack_take = o_int_req && i_int_ack;

  // clear on acknowledge; the shared vector keeps both flags if both enabled
  always_comb begin
    ack_clr = '0;
    if (ack_take) begin
      if (o_int_vector == 3'h1) begin
        if (!(en_flag[vic_pkg::F_BT] && en_flag[vic_pkg::F_PIN_D])) begin
          ack_clr[vic_pkg::F_BT] = en_flag[vic_pkg::F_BT];
          ack_clr[vic_pkg::F_PIN_D] = en_flag[vic_pkg::F_PIN_D];
        end
      end else begin
        ack_clr[o_int_vector] = 1'b1;
      end
    end
  end

  // servicing status: acceptance steps up, return restores the saved value
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      service_status <= vic_pkg::ST_0;
    end else if (ack_take) begin
      service_status <= service_status + 1'b1;
    end else if (i_reti) begin
      service_status <= i_reti_status;
    end else if (i_status_wr) begin
      service_status <= i_status_wdata;
    end
  end

  assign o_service_status = service_status;

  // read data registered one cycle after the read strobe
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_mem_rdata <= 4'h0;
    end else if (i_mem_rd) begin
      if (i_mem_addr == vic_pkg::ADDR_IPS) begin
        o_mem_rdata <= interrupt_priority_select;
      end else if (i_mem_addr == vic_pkg::ADDR_IM_A) begin
        o_mem_rdata <= im_a;
      end else if (i_mem_addr == vic_pkg::ADDR_IM_B) begin
        o_mem_rdata <= im_b;
      end else if (i_mem_addr == vic_pkg::ADDR_REQ_BASE) begin
        o_mem_rdata <= req_pad[3:0];
      end else if (i_mem_addr == vic_pkg::ADDR_REQ_BASE + 12'h001) begin
        o_mem_rdata <= req_pad[7:4];
      end else if (i_mem_addr == vic_pkg::ADDR_REQ_BASE + 12'h002) begin
        o_mem_rdata <= req_pad[11:8];
      end else if (i_mem_addr == vic_pkg::ADDR_EN_BASE) begin
        o_mem_rdata <= en_pad[3:0];
      end else if (i_mem_addr == vic_pkg::ADDR_EN_BASE + 12'h001) begin
        o_mem_rdata <= en_pad[7:4];
      end else if (i_mem_addr == vic_pkg::ADDR_EN_BASE + 12'h002) begin
        o_mem_rdata <= en_pad[11:8];
      end else begin
        o_mem_rdata <= 4'h0;
      end
    end
  end

endmodule // vic_top

// [vic_top_properties.sv]
// port checker of the vectored interrupt controller
`timescale 1ns/1ps
module vic_top_properties (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_instr_boundary,
  input wire logic i_int_ack,
  input wire logic [6:0] o_vectored_request_line,
  input wire logic [9:0] o_wakeup,
  input wire logic o_int_req,
  input wire logic [2:0] o_int_vector,
  input wire logic [13:0] o_vector_addr,
  input wire logic [1:0] o_service_status
);
  logic [6:0] prev_vrl;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // request lines as seen at the deciding edge
  always_ff @(posedge i_mclk) begin
    prev_vrl <= o_vectored_request_line;
  end
  wake_map_a: assert property (
    o_vectored_request_line == {o_wakeup[7:2], o_wakeup[0] | o_wakeup[1]})
    else $error("request lines differ from wake-up lines");
  boundary_start_a: assert property ($rose(o_int_req) |-> $past(i_instr_boundary))
    else $error("request presented off a boundary");
  hold_req_a: assert property (o_int_req && !i_int_ack |=>
    o_int_req && $stable(o_int_vector) && $stable(o_vector_addr))
    else $error("request not held until ack");
  drop_req_a: assert property (o_int_req && i_int_ack |=> !o_int_req)
    else $error("request kept after ack");
  status_step_a: assert property (o_int_req && i_int_ack |=>
    o_service_status == $past(o_service_status) + 2'h1)
    else $error("status did not advance by one");
  vector_addr_a: assert property (o_int_req |-> o_vector_addr == {10'h000, o_int_vector, 1'b0})
    else $error("vector address wrong");
  status_two_a: assert property ($rose(o_int_req) |-> $past(o_service_status) != vic_pkg::ST_2)
    else $error("request accepted in status two");
  vector_live_a: assert property ($rose(o_int_req) |->
    o_int_vector != 3'h0 && prev_vrl[o_int_vector - 3'h1])
    else $error("presented vector had no request");
  lowest_first_a: assert property ($rose(o_int_req) && $past(o_service_status) == vic_pkg::ST_0 |->
    (prev_vrl & ((7'h01 << (o_int_vector - 3'h1)) - 7'h01)) == 7'h00)
    else $error("lower request was pending");
endmodule // vic_top_properties

bind vic_top vic_top_properties u_vic_props (.i_mclk, .i_nrst, .i_instr_boundary, .i_int_ack,
  .o_vectored_request_line, .o_wakeup, .o_int_req, .o_int_vector, .o_vector_addr,
  .o_service_status);
